//--- hdl/lesup_pkg.sv
// Function
// - streaming timer starts when the remote hands link ownership back
// - streaming timer stops as soon as the remote drops carrier
// - streaming timer expiry posts a control response like babbling tributary
// - babbling-style response carries error code and offending tributary identity
// - no own transmission while remote still holds carrier after handing back
// - streaming period defaults to one second when software gives none
// - seven error and three statistical counters per tributary, four global
// - statistical counters 16 bits, threshold counters 3 bits, others 8 bits
// - command reads a counter or reads and clears it, unless an event counts it in that cycle; value returned
// - threshold counters wrap to zero at maximum; never cleared by software
// - inbound data error counter counts validity errors; another counts messages
// - counters freeze while the protocol is halted
// - procedural codes 100 to 140 reported, no recovery needed
// - codes 300 and 302 report shutdown-level and fatal-level recovery
// - invalid buffer address access posts response with failing address
// - reported address may be already advanced; software sorts transmit from receive
// - tributary halt returns every outstanding buffer of that tributary
// - global halt returns every outstanding common pool receive buffer
// - out-of-sequence message is ignored before buffer allocation
// - pool tried first only if enabled, quota nonzero and buffer available
// - pool buffer too small falls to private; none there gives too-small nak
// - private list reached directly and empty gives temporarily-unavailable nak
// - private buffer too small gives too-small nak, else it is used
// - only the next buffer of each list is taken, lists never searched
package lesup_pkg;
	// ---------------------------------------------------------------
	// bus map
	// ---------------------------------------------------------------
	localparam logic [7:0] LESUP_A_CTRL   = 8'h00;
	localparam logic [7:0] LESUP_A_PERIOD = 8'h04;
	localparam logic [7:0] LESUP_A_STATUS = 8'h08;
	localparam logic [7:0] LESUP_A_CNTCMD = 8'h0C;
	localparam logic [7:0] LESUP_A_CNTVAL = 8'h10;
	localparam logic [7:0] LESUP_A_RESP   = 8'h14;
	localparam logic [7:0] LESUP_A_RXCMD  = 8'h18;
	localparam logic [7:0] LESUP_A_RXRES  = 8'h1C;
	localparam logic [7:0] LESUP_A_NXMADR = 8'h20;
	localparam logic [7:0] LESUP_A_RESPOP = 8'h24;
	// ctrl bits
	localparam int LESUP_B_HALT   = 0;
	localparam int LESUP_B_GHALT  = 1;
	localparam int LESUP_B_POOLEN = 2;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int LESUP_CLK_HZ        = 100_000_000;
	localparam int LESUP_STREAM_MS     = 1000;
	localparam int LESUP_STREAM_CYCLES = LESUP_CLK_HZ / 1000 * LESUP_STREAM_MS;
	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	localparam int LESUP_N_TERR  = 7;
	localparam int LESUP_N_TSTAT = 3;
	localparam int LESUP_N_GERR  = 4;
	localparam int LESUP_N_THR   = 3;
	localparam int LESUP_N_CNT   = LESUP_N_TERR + LESUP_N_TSTAT + LESUP_N_GERR;
	localparam int LESUP_W_STAT  = 16;
	localparam int LESUP_W_THR   = 3;
	localparam int LESUP_W_ERR   = 8;
	// counter index layout: 0..2 threshold, 3..6 tributary error, 7..9 stats, 10..13 global
	localparam int LESUP_I_THR0   = 0;
	localparam int LESUP_I_DATERR = 3;
	localparam int LESUP_I_STAT0  = 7;
	localparam int LESUP_I_DATMSG = 7;
	localparam int LESUP_I_GERR0  = 10;
	// ---------------------------------------------------------------
	// response codes
	// ---------------------------------------------------------------
	localparam logic [9:0] LESUP_C_STREAM  = 10'h020;
	localparam logic [9:0] LESUP_C_PROC_LO = 10'd100;
	localparam logic [9:0] LESUP_C_PROC_HI = 10'd140;
	localparam logic [9:0] LESUP_C_SHUT    = 10'd300;
	localparam logic [9:0] LESUP_C_FATAL   = 10'd302;
	localparam logic [9:0] LESUP_C_NXM     = 10'd300;
	localparam logic [1:0] LESUP_LVL_NONE  = 2'h0;
	localparam logic [1:0] LESUP_LVL_SHUT  = 2'h1;
	localparam logic [1:0] LESUP_LVL_FATAL = 2'h2;
	typedef enum logic [2:0] {
		LESUP_RX_USE_POOL = 3'h1,
		LESUP_RX_USE_PRIV = 3'h2,
		LESUP_RX_IGNORE   = 3'h3,
		LESUP_RX_NAK_TMP  = 3'h4,
		LESUP_RX_NAK_SMALL= 3'h5
	} lesup_rx_e;
endpackage

//--- hdl/lesup_ev_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lesup_ev_if;
	import lesup_pkg::*;
	logic        valid;
	logic [9:0]  code;
	logic [7:0]  trib;
	logic [1:0]  level;
	modport src (output valid, output code, output trib, output level);
	modport dst (input valid, input code, input trib, input level);
endinterface
`default_nettype wire

//--- hdl/lesup_stream_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lesup_stream_timer
	import lesup_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        own_back,
	input  wire logic        carrier,
	input  wire logic [31:0] period,
	input  wire logic [7:0]  trib_id,
	output logic             tx_block,
	lesup_ev_if.src          ev
);
	logic        run_reg;
	logic        fired_reg;
	logic [31:0] cnt_reg;
	wire         expire = run_reg && !fired_reg && (cnt_reg >= period - 32'h1);
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			run_reg   <= 1'b0;
			fired_reg <= 1'b0;
			cnt_reg   <= 32'h0;
		end else if (own_back && carrier) begin
			run_reg   <= 1'b1;
			fired_reg <= 1'b0;
			cnt_reg   <= 32'h0;
		end else if (!carrier) begin
			run_reg   <= 1'b0;
			cnt_reg   <= 32'h0;
		end else if (run_reg) begin
			cnt_reg   <= cnt_reg + 32'h1;
			if (expire)
				fired_reg <= 1'b1;
		end
	end
	// hold transmit off until the remote lets carrier go
	assign tx_block = run_reg && carrier;
	assign ev.valid = expire;
	assign ev.code  = LESUP_C_STREAM;
	assign ev.trib  = trib_id;
	assign ev.level = LESUP_LVL_SHUT;
endmodule
`default_nettype wire

//--- hdl/lesup_rx_select.sv
`timescale 1ns/1ps
`default_nettype none
module lesup_rx_select
	import lesup_pkg::*;
(
	input  wire logic       in_seq,
	input  wire logic       pool_en,
	input  wire logic [7:0] quota,
	input  wire logic       pool_avail,
	input  wire logic       pool_small,
	input  wire logic       priv_avail,
	input  wire logic       priv_small,
	output lesup_rx_e       outcome
);
	// only list heads are inspected, never a search
	wire try_pool = pool_en && (quota != 8'h0) && pool_avail;
	always_comb begin
		if (!in_seq)
			outcome = LESUP_RX_IGNORE;
		else if (try_pool && !pool_small)
			outcome = LESUP_RX_USE_POOL;
		else if (try_pool)
			outcome = (priv_avail && !priv_small) ? LESUP_RX_USE_PRIV : LESUP_RX_NAK_SMALL;
		else if (!priv_avail)
			outcome = LESUP_RX_NAK_TMP;
		else
			outcome = priv_small ? LESUP_RX_NAK_SMALL : LESUP_RX_USE_PRIV;
	end
endmodule
`default_nettype wire

//--- hdl/lesup_top.sv
`timescale 1ns/1ps
`default_nettype none
module lesup_top
	import lesup_pkg::*;
#(
	parameter int STREAM_DEFAULT = LESUP_STREAM_CYCLES
)(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_own_back,
	input  wire logic        link_carrier,
	input  wire logic [7:0]  link_trib_id,
	input  wire logic        ev_in_valid,
	input  wire logic [LESUP_N_CNT-1:0] ev_in_vec,
	input  wire logic        proc_err_valid,
	input  wire logic [9:0]  proc_err_code,
	input  wire logic        nxm_valid,
	input  wire logic [31:0] nxm_addr,
	output logic             tx_inhibit,
	output logic             ret_trib_bufs,
	output logic             ret_pool_bufs
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] own_s_reg;
	logic [1:0] car_s_reg;
	// id is steady around a hand-back, so a bitwise two-stage sync is enough
	logic [7:0] trib_s1_reg;
	logic [7:0] trib_s2_reg;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			own_s_reg   <= 2'h0;
			car_s_reg   <= 2'h0;
			trib_s1_reg <= 8'h0;
			trib_s2_reg <= 8'h0;
		end else begin
			own_s_reg   <= {own_s_reg[0], link_own_back};
			car_s_reg   <= {car_s_reg[0], link_carrier};
			trib_s1_reg <= link_trib_id;
			trib_s2_reg <= trib_s1_reg;
		end
	end
	logic own_d_reg;
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			own_d_reg <= 1'b0;
		else
			own_d_reg <= own_s_reg[1];
	end
	wire own_rise = own_s_reg[1] && !own_d_reg;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [2:0]  ctrl_reg;
	logic [31:0] period_reg;
	logic        period_set_reg;
	logic [3:0]  sel_idx_reg;
	logic [31:0] cnt_val_reg;
	logic [31:0] nxm_reg;
	logic        resp_v_reg;
	logic [9:0]  resp_code_reg;
	logic [7:0]  resp_trib_reg;
	logic [1:0]  resp_lvl_reg;
	logic [6:0]  rx_cmd_reg;
	wire halted  = ctrl_reg[LESUP_B_HALT];
	wire acc     = psel && penable;
	wire wr      = acc && pwrite;
	wire rd      = acc && !pwrite;
	wire mapped  = (paddr == LESUP_A_CTRL) || (paddr == LESUP_A_PERIOD) ||
	               (paddr == LESUP_A_STATUS) || (paddr == LESUP_A_CNTCMD) ||
	               (paddr == LESUP_A_CNTVAL) || (paddr == LESUP_A_RESP) ||
	               (paddr == LESUP_A_RXCMD) || (paddr == LESUP_A_RXRES) ||
	               (paddr == LESUP_A_NXMADR) || (paddr == LESUP_A_RESPOP);
	wire wr_ctrl = wr && (paddr == LESUP_A_CTRL);
	wire wr_per  = wr && (paddr == LESUP_A_PERIOD);
	wire wr_cmd  = wr && (paddr == LESUP_A_CNTCMD);
	wire wr_rx   = wr && (paddr == LESUP_A_RXCMD);
	wire wr_pop  = wr && (paddr == LESUP_A_RESPOP);
	wire [31:0] eff_period = period_set_reg ? period_reg : 32'(STREAM_DEFAULT);

	// ---------------------------------------------------------------
	// streaming timer and rx selection
	// ---------------------------------------------------------------
	lesup_ev_if st_ev();
	lesup_stream_timer u_st (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.own_back(own_rise),
		.carrier (car_s_reg[1]),
		.period  (eff_period),
		.trib_id (trib_s2_reg),
		.tx_block(tx_inhibit),
		.ev      (st_ev)
	);
	lesup_rx_e rx_out;
	lesup_rx_select u_rx (
		.in_seq    (rx_cmd_reg[0]),
		.pool_en   (ctrl_reg[LESUP_B_POOLEN]),
		.quota     ({7'h0, rx_cmd_reg[1]}),
		.pool_avail(rx_cmd_reg[2]),
		.pool_small(rx_cmd_reg[3]),
		.priv_avail(rx_cmd_reg[4]),
		.priv_small(rx_cmd_reg[5]),
		.outcome   (rx_out)
	);

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	function automatic logic [4:0] cnt_width(input int i);
		if (i < LESUP_I_DATERR)
			return 5'(LESUP_W_THR);
		else if (i >= LESUP_I_STAT0 && i < LESUP_I_GERR0)
			return 5'(LESUP_W_STAT);
		else
			return 5'(LESUP_W_ERR);
	endfunction
	logic [15:0] cnt_reg [LESUP_N_CNT];
	wire         clr_cmd = wr_cmd && pwdata[4];
	wire [3:0]   cmd_idx = pwdata[3:0];
	genvar gi;
	generate
		for (gi = 0; gi < LESUP_N_CNT; gi++) begin : g_cnt
			localparam logic [15:0] MAXV = 16'((32'h1 << cnt_width(gi)) - 1);
			wire inc = ev_in_valid && ev_in_vec[gi] && !halted;
			wire clr = clr_cmd && (cmd_idx == 4'(gi)) && (gi >= LESUP_N_THR);
			always_ff @(posedge sys_clk) begin
				if (!reset_n)
					cnt_reg[gi] <= 16'h0;
				else if (inc)
					cnt_reg[gi] <= (cnt_reg[gi] == MAXV) ? 16'h0 : cnt_reg[gi] + 16'h1;
				else if (clr)
					cnt_reg[gi] <= 16'h0;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// response latch
	// ---------------------------------------------------------------
	wire proc_ok   = proc_err_valid && ((proc_err_code >= LESUP_C_PROC_LO && proc_err_code <= LESUP_C_PROC_HI) ||
	                 proc_err_code == LESUP_C_SHUT || proc_err_code == LESUP_C_FATAL);
	wire [1:0] proc_lvl = (proc_err_code == LESUP_C_FATAL) ? LESUP_LVL_FATAL :
	                      (proc_err_code == LESUP_C_SHUT) ? LESUP_LVL_SHUT : LESUP_LVL_NONE;
	// one slot: a new event overwrites an unread one; posting wins over pop
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			resp_v_reg    <= 1'b0;
			resp_code_reg <= 10'h0;
			resp_trib_reg <= 8'h0;
			resp_lvl_reg  <= 2'h0;
			nxm_reg       <= 32'h0;
		end else if (st_ev.valid) begin
			resp_v_reg    <= 1'b1;
			resp_code_reg <= st_ev.code;
			resp_trib_reg <= st_ev.trib;
			resp_lvl_reg  <= st_ev.level;
		end else if (nxm_valid) begin
			resp_v_reg    <= 1'b1;
			resp_code_reg <= LESUP_C_NXM;
			resp_lvl_reg  <= LESUP_LVL_SHUT;
			nxm_reg       <= nxm_addr;
		end else if (proc_ok) begin
			resp_v_reg    <= 1'b1;
			resp_code_reg <= proc_err_code;
			resp_lvl_reg  <= proc_lvl;
		end else if (wr_pop)
			resp_v_reg    <= 1'b0;
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_reg       <= 3'h0;
			period_reg     <= 32'h0;
			period_set_reg <= 1'b0;
			sel_idx_reg    <= 4'h0;
			cnt_val_reg    <= 32'h0;
			rx_cmd_reg     <= 7'h0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= pwdata[2:0];
			if (wr_per) begin
				period_reg     <= pwdata;
				period_set_reg <= (pwdata != 32'h0);
			end
			if (wr_cmd) begin
				sel_idx_reg <= cmd_idx;
				cnt_val_reg <= (cmd_idx < 4'(LESUP_N_CNT)) ? {16'h0, cnt_reg[cmd_idx]} : 32'h0;
			end
			if (wr_rx)
				rx_cmd_reg <= {1'b1, pwdata[5:0]};
		end
	end
	// halt edges return outstanding buffers
	logic [1:0] halt_d_reg;
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			halt_d_reg <= 2'h0;
		else
			halt_d_reg <= ctrl_reg[1:0];
	end
	assign ret_trib_bufs = ctrl_reg[LESUP_B_HALT] && !halt_d_reg[0];
	assign ret_pool_bufs = ctrl_reg[LESUP_B_GHALT] && !halt_d_reg[1];

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	wire [31:0] rd_mux =
		(paddr == LESUP_A_CTRL)   ? {29'h0, ctrl_reg} :
		(paddr == LESUP_A_PERIOD) ? eff_period :
		(paddr == LESUP_A_STATUS) ? {30'h0, tx_inhibit, resp_v_reg} :
		(paddr == LESUP_A_CNTCMD) ? {28'h0, sel_idx_reg} :
		(paddr == LESUP_A_CNTVAL) ? cnt_val_reg :
		(paddr == LESUP_A_RESP)   ? {11'h0, resp_v_reg, resp_lvl_reg, resp_trib_reg, resp_code_reg} :
		(paddr == LESUP_A_RXCMD)  ? {25'h0, rx_cmd_reg} :
		(paddr == LESUP_A_RXRES)  ? {28'h0, rx_cmd_reg[6], rx_out} :
		(paddr == LESUP_A_NXMADR) ? nxm_reg : 32'h0;
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	wire unused_ok = rd;
endmodule
`default_nettype wire

//--- sim/lesup_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lesup_top_sva
	import lesup_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic        link_carrier,
	input  wire logic        tx_inhibit,
	input  wire logic        ret_trib_bufs,
	input  wire logic        ret_pool_bufs
);
	// ------
	// decode
	// ------
	wire logic acc = psel && penable;
	wire logic bad = (paddr > LESUP_A_RESPOP) || (paddr[1:0] != 2'h0);
	wire logic wr_c = acc && pwrite && (paddr == LESUP_A_CTRL);
	wire logic wr_h = wr_c && pwdata[LESUP_B_HALT];
	wire logic wr_g = wr_c && pwdata[LESUP_B_GHALT];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_mapped_noerr: assert property (acc && !bad |-> !pslverr)
		else $error("error on mapped access");
	a_unmapped_err: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped access");
	a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	// status is latched at setup, so compare with the setup-cycle value
	a_status_inhibit: assert property (acc && !pwrite && paddr == LESUP_A_STATUS |-> prdata[1] == $past(tx_inhibit))
		else $error("status inhibit bit wrong");
	a_inhibit_drop: assert property (!link_carrier [*5] |-> !tx_inhibit)
		else $error("inhibit held without carrier");
	a_trib_pulse: assert property (ret_trib_bufs |=> !ret_trib_bufs)
		else $error("tributary return not a pulse");
	a_trib_cause: assert property (ret_trib_bufs |-> $past(wr_h) || $past(wr_h, 2))
		else $error("tributary return without halt");
	a_pool_pulse: assert property (ret_pool_bufs |=> !ret_pool_bufs)
		else $error("pool return not a pulse");
	a_pool_cause: assert property (ret_pool_bufs |-> $past(wr_g) || $past(wr_g, 2))
		else $error("pool return without global halt");
endmodule
bind lesup_top lesup_top_sva lesup_top_sva_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .link_carrier, .tx_inhibit, .ret_trib_bufs, .ret_pool_bufs);
`default_nettype wire

//--- sim/lesup_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module lesup_remote_model #(
	parameter logic [7:0] TRIB = 8'h2A
)(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       go,
	input  wire logic [7:0] hold,
	output logic            own_back,
	output logic            carrier,
	output logic [7:0]      trib_id
);
	// ------
	// remote station
	// ------
	logic [7:0] cnt_reg;
	assign trib_id = TRIB;
	// carrier stays up past the hand-back, as a streaming station does
	assign carrier = cnt_reg != 8'h0;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_reg  <= 8'h0;
			own_back <= 1'b0;
		end else begin
			own_back <= carrier;
			if (go) begin
				cnt_reg <= hold;
			end else if (cnt_reg != 8'h0) begin
				cnt_reg <= cnt_reg - 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/tb_lesup_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lesup_top;
	import lesup_pkg::*;
	// ------
	// harness
	// ------
	logic                   sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [7:0]             paddr = 0, hold = 0, trib;
	logic [31:0]            pwdata = 0, nxm_addr = 0, prdata, rd;
	logic                   pready, pslverr, err, own_back, carrier, tx_inhibit, ret_trib_bufs, ret_pool_bufs;
	logic                   ev_in_valid = 0, proc_err_valid = 0, nxm_valid = 0;
	logic [LESUP_N_CNT-1:0] ev_in_vec = 0;
	logic [9:0]             proc_err_code = 0;
	int                     err_total = 0, num_checks = 0, seen_t = 0, seen_p = 0;
	logic [9:0]             pc[4] = '{10'd100, 10'd140, 10'd300, 10'd302};
	logic [1:0]             pl[4] = '{LESUP_LVL_NONE, LESUP_LVL_NONE, LESUP_LVL_SHUT, LESUP_LVL_FATAL};
	logic                   xe[10] = '{1, 1, 0, 1, 1, 1, 1, 1, 0, 0};
	logic [5:0]             xc[10] = '{6'h06, 6'h07, 6'h17, 6'h15, 6'h13, 6'h1F, 6'h0F, 6'h3F, 6'h01, 6'h31};
	lesup_rx_e              xo[10] = '{LESUP_RX_IGNORE, LESUP_RX_USE_POOL, LESUP_RX_USE_PRIV, LESUP_RX_USE_PRIV,
		LESUP_RX_USE_PRIV, LESUP_RX_USE_PRIV, LESUP_RX_NAK_SMALL, LESUP_RX_NAK_SMALL, LESUP_RX_NAK_TMP, LESUP_RX_NAK_SMALL};
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		seen_t <= seen_t + int'(ret_trib_bufs === 1'b1);
		seen_p <= seen_p + int'(ret_pool_bufs === 1'b1);
	end
	lesup_top #(.STREAM_DEFAULT(20)) lesup_top_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link_own_back(own_back), .link_carrier(carrier), .link_trib_id(trib),
		.ev_in_valid, .ev_in_vec, .proc_err_valid, .proc_err_code, .nxm_valid, .nxm_addr, .tx_inhibit,
		.ret_trib_bufs, .ret_pool_bufs);
	lesup_remote_model lesup_remote_model_i (.sys_clk, .reset_n, .go, .hold, .own_back, .carrier, .trib_id(trib));
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		// pready ends this wait; lesup_top ties it high, so it lasts one cycle
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(0, a, 0);
		chk(n, e, rd & m);
	endtask
	task cnt(input logic [3:0] i, input logic c, input logic [31:0] e);
		apb(1, LESUP_A_CNTCMD, {27'h0, c, i});
		rdc("counter", LESUP_A_CNTVAL, e, 32'hFFFF_FFFF);
	endtask
	task ev(input logic [LESUP_N_CNT-1:0] v, input int n);
		@(posedge sys_clk);
		ev_in_valid <= 1; ev_in_vec <= v;
		repeat (n) @(posedge sys_clk);
		ev_in_valid <= 0;
	endtask
	task link(input logic [7:0] h);
		@(posedge sys_clk);
		go <= 1; hold <= h;
		@(posedge sys_clk);
		go <= 0;
	endtask
	// ------
	// tests
	// ------
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1;
		apb(0, 8'h28, 0); chk("unmapped read", 32'h0, rd); chk("unmapped err", 1, err);
		apb(1, 8'h2C, 1); chk("unmapped write err", 1, err);
		$display("bus test done");
		link(100); repeat (8) @(posedge sys_clk);
		rdc("inhibit on", LESUP_A_STATUS, 2, 2);
		rdc("no early expiry", LESUP_A_RESP, 0, 32'h0010_0000);
		repeat (30) @(posedge sys_clk);
		rdc("stream resp", LESUP_A_RESP, {11'h0, 1'b1, LESUP_LVL_SHUT, 8'h2A, LESUP_C_STREAM}, '1);
		repeat (80) @(posedge sys_clk);
		rdc("inhibit off", LESUP_A_STATUS, 0, 2);
		apb(1, LESUP_A_RESPOP, 0);
		apb(1, LESUP_A_PERIOD, 40);
		rdc("period", LESUP_A_PERIOD, 40, '1);
		link(30); repeat (60) @(posedge sys_clk);
		rdc("stopped timer", LESUP_A_RESP, 0, 32'h0010_0000);
		link(100); repeat (50) @(posedge sys_clk);
		rdc("programmed expiry", LESUP_A_RESP, {11'h0, 1'b1, LESUP_LVL_SHUT, 8'h2A, LESUP_C_STREAM}, '1);
		apb(1, LESUP_A_RESPOP, 0); repeat (60) @(posedge sys_clk);
		apb(1, LESUP_A_PERIOD, 0);
		rdc("default period", LESUP_A_PERIOD, 20, '1);
		$display("stream test done");
		ev(14'h0089, 3); cnt(3, 0, 3); cnt(7, 0, 3);
		cnt(0, 1, 3); cnt(0, 0, 3);
		cnt(3, 1, 3); cnt(3, 0, 0);
		ev(14'h0001, 5); cnt(0, 0, 0);
		ev(14'h0480, 256); cnt(7, 0, 259); cnt(10, 0, 0);
		apb(1, LESUP_A_CTRL, 1); ev(14'h0080, 2); cnt(7, 0, 259);
		apb(1, LESUP_A_CTRL, 0); apb(1, LESUP_A_CTRL, 2); apb(1, LESUP_A_CTRL, 0);
		chk("trib return", 1, seen_t); chk("pool return", 1, seen_p);
		$display("counter test done");
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			proc_err_valid <= 1; proc_err_code <= pc[i];
			@(posedge sys_clk);
			proc_err_valid <= 0;
			rdc("proc resp", LESUP_A_RESP, {11'h0, 1'b1, pl[i], 8'h0, pc[i]}, 32'h001C_03FF);
			apb(1, LESUP_A_RESPOP, 0);
		end
		@(posedge sys_clk);
		nxm_valid <= 1; nxm_addr <= 32'h0001_2346;
		@(posedge sys_clk);
		nxm_valid <= 0;
		rdc("nxm addr", LESUP_A_NXMADR, 32'h0001_2346, '1);
		rdc("nxm resp", LESUP_A_RESP, {11'h0, 1'b1, LESUP_LVL_SHUT, 8'h0, LESUP_C_NXM}, 32'h001C_03FF);
		apb(1, LESUP_A_RESPOP, 0);
		$display("error test done");
		for (int i = 0; i < 10; i++) begin
			apb(1, LESUP_A_CTRL, {29'h0, xe[i], 2'h0});
			apb(1, LESUP_A_RXCMD, {26'h0, xc[i]});
			rdc("rx outcome", LESUP_A_RXRES, {28'h1, xo[i]}, 32'hF);
		end
		$display("buffer test done");
		finish_test;
	end
	initial begin
		#200_000;
		err_total++;
		$display("watchdog expired");
		finish_test;
	end
endmodule
`default_nettype wire
